// >>> hdl/tac_alarm_ctrl.sv
// Alarm thresholds, configuration and alert pin control behind Wishbone.
`timescale 1ns/1ps
`default_nettype none
module tac_alarm_ctrl
	import tac_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [TAC_AW-1:0] wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// Sensor link, asynchronous to clk_i
	input  wire logic              sample_clk_i,
	input  wire logic [11:0]       temp_i,
	input  wire logic              crit_alarm_i,
	// Alert pin
	output logic                   alert_o,
	output logic                   alert_oen_o
);

	// Link synchronisers.
	logic        sclk_s1_q;
	logic        sclk_s2_q;
	logic        sclk_s3_q;
	logic [11:0] temp_s1_q;
	logic [11:0] temp_s2_q;
	logic        crit_s1_q;
	logic        crit_s2_q;

	// Sample capture.
	logic [11:0] temp_q;
	logic        sample_q;
	logic        sclk_rise;

	// Configuration state.
	logic        en_q;
	logic        crit_only_q;
	logic        pol_q;
	tac_mode_t   mode_q;
	logic        wlock_q;
	logic        clock_q;
	logic        shdn_q;
	logic [1:0]  hyst_q;
	logic        status_q;

	// Threshold state.
	logic [TAC_THR_W-1:0] upper_q;
	logic [TAC_THR_W-1:0] lower_q;

	// Alarm tracking.
	logic        upper_p_q;
	logic        lower_p_q;
	logic        crit_p_q;
	logic        latch_q;
	logic        alarm_lvl;
	logic        alarm_evt;
	logic        active;
	logic        asserted;

	// Bus decode.
	logic        ack_q;
	logic        req;
	logic        wr;
	logic [5:0]  idx;
	logic        lock_any;
	logic        cfg_wr;
	logic        clr;
	logic [15:0] cfg_view;
	logic [15:0] cfg_wd;
	logic [15:0] upper_wd;
	logic [15:0] lower_wd;
	logic [15:0] rd_data;

	tac_cmp_if cmp_bus ();

	// Replace only the byte lanes that the master selects.
	function automatic logic [15:0] lane_merge(
		input logic [15:0] old_val,
		input logic [31:0] wdat,
		input logic [3:0]  sel
	);
		lane_merge[7:0]  = sel[0] ? wdat[7:0] : old_val[7:0];
		lane_merge[15:8] = sel[1] ? wdat[15:8] : old_val[15:8];
	endfunction

	// Threshold register image with reserved bits forced to zero.
	function automatic logic [15:0] thr_view(
		input logic [TAC_THR_W-1:0] thr
	);
		thr_view = {3'h0, thr, 2'h0};
	endfunction

	// Every link input passes two flip-flops before any logic reads it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			temp_s1_q <= 12'h000;
			temp_s2_q <= 12'h000;
			crit_s1_q <= 1'b0;
			crit_s2_q <= 1'b0;
		end else begin
			sclk_s1_q <= sample_clk_i;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			temp_s1_q <= temp_i;
			temp_s2_q <= temp_s1_q;
			crit_s1_q <= crit_alarm_i;
			crit_s2_q <= crit_s1_q;
		end
	end

	assign sclk_rise = sclk_s2_q & ~sclk_s3_q;

	// Sampling stops in shutdown, so the comparators hold their state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			temp_q   <= 12'h000;
			sample_q <= 1'b0;
		end else begin
			sample_q <= sclk_rise & ~shdn_q;
			if (sclk_rise && !shdn_q) begin
				temp_q <= temp_s2_q;
			end
		end
	end

	assign cmp_bus.sample = sample_q;
	assign cmp_bus.temp   = temp_q;
	assign cmp_bus.upper  = upper_q;
	assign cmp_bus.lower  = lower_q;
	assign cmp_bus.hyst   = hyst_q;

	tac_window_cmp u_cmp (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.bus   (cmp_bus.cmp)
	);

	// Bus request decode; a write acts at the edge that raises ack.
	assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr       = req & wb_we_i;
	assign idx      = wb_adr_i[7:2];
	assign lock_any = wlock_q | clock_q;
	assign cfg_wr   = wr & (idx == TAC_IDX_CFG);

	assign cfg_view = {5'h00, hyst_q, shdn_q, clock_q, wlock_q,
		1'b0, status_q, en_q, crit_only_q, pol_q, mode_q};
	assign cfg_wd   = lane_merge(cfg_view, wb_dat_i, wb_sel_i);
	assign upper_wd = lane_merge(thr_view(upper_q), wb_dat_i, wb_sel_i);
	assign lower_wd = lane_merge(thr_view(lower_q), wb_dat_i, wb_sel_i);

	// Locks are sampled before the write, so a write that sets a lock
	// still updates the other fields it carries.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_q   <= TAC_CFG_RESET[TAC_CFG_EN];
			pol_q  <= TAC_CFG_RESET[TAC_CFG_POL];
			mode_q <= tac_mode_t'(TAC_CFG_RESET[TAC_CFG_MODE]);
			shdn_q <= TAC_CFG_RESET[TAC_CFG_SHDN];
			hyst_q <= TAC_CFG_RESET[TAC_CFG_HYST_H:TAC_CFG_HYST_L];
		end else if (cfg_wr && !lock_any) begin
			en_q   <= cfg_wd[TAC_CFG_EN];
			pol_q  <= cfg_wd[TAC_CFG_POL];
			mode_q <= tac_mode_t'(cfg_wd[TAC_CFG_MODE]);
			shdn_q <= cfg_wd[TAC_CFG_SHDN];
			hyst_q <= cfg_wd[TAC_CFG_HYST_H:TAC_CFG_HYST_L];
		end
	end

	// The critical-trip lock alone does not freeze this bit.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			crit_only_q <= TAC_CFG_RESET[TAC_CFG_CRIT];
		end else if (cfg_wr && !wlock_q) begin
			crit_only_q <= cfg_wd[TAC_CFG_CRIT];
		end
	end

	// Lock bits can only be set; reset is the sole way back.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wlock_q <= TAC_CFG_RESET[TAC_CFG_WLOCK];
			clock_q <= TAC_CFG_RESET[TAC_CFG_CLOCK];
		end else if (cfg_wr) begin
			wlock_q <= wlock_q | cfg_wd[TAC_CFG_WLOCK];
			clock_q <= clock_q | cfg_wd[TAC_CFG_CLOCK];
		end
	end

	// Thresholds keep only bits 12:2; the rest is never stored.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			upper_q <= TAC_THR_RESET;
			lower_q <= TAC_THR_RESET;
		end else if (wr && !wlock_q) begin
			if (idx == TAC_IDX_UPPER) begin
				upper_q <= upper_wd[TAC_THR_MSB:TAC_THR_LSB];
			end
			if (idx == TAC_IDX_LOWER) begin
				lower_q <= lower_wd[TAC_THR_MSB:TAC_THR_LSB];
			end
		end
	end

	// Alarm level and events, narrowed to the critical input if selected.
	always_comb begin
		if (crit_only_q) begin
			alarm_lvl = crit_s2_q;
			alarm_evt = crit_s2_q & ~crit_p_q;
		end else begin
			alarm_lvl = cmp_bus.upper_cond | cmp_bus.lower_cond | crit_s2_q;
			alarm_evt = (cmp_bus.upper_cond & ~upper_p_q)
				| (cmp_bus.lower_cond ^ lower_p_q)
				| (crit_s2_q & ~crit_p_q);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			upper_p_q <= 1'b0;
			lower_p_q <= 1'b0;
			crit_p_q  <= 1'b0;
		end else begin
			upper_p_q <= cmp_bus.upper_cond;
			lower_p_q <= cmp_bus.lower_cond;
			crit_p_q  <= crit_s2_q;
		end
	end

	// The clear bit is self-clearing: it is never stored, only acted on.
	assign clr = cfg_wr & cfg_wd[TAC_CFG_CLR] & (mode_q == TAC_MODE_INT);

	// A new event in the cycle of a clear keeps the latch set.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_q <= 1'b0;
		end else if (shdn_q || !en_q || mode_q == TAC_MODE_CMP) begin
			latch_q <= 1'b0;
		end else if (alarm_evt) begin
			latch_q <= 1'b1;
		end else if (clr) begin
			latch_q <= 1'b0;
		end
	end

	always_comb begin
		case (mode_q)
			TAC_MODE_CMP: active = alarm_lvl;
			TAC_MODE_INT: active = latch_q;
			default: active = 1'b0;
		endcase
	end

	assign asserted = active & en_q & ~shdn_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= 1'b0;
		end else begin
			status_q <= asserted;
		end
	end

	// Active low works open-drain: the pin is only ever pulled low.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alert_o     <= 1'b0;
			alert_oen_o <= 1'b1;
		end else if (shdn_q) begin
			alert_o     <= 1'b0;
			alert_oen_o <= 1'b1;
		end else if (!pol_q) begin
			alert_o     <= 1'b0;
			alert_oen_o <= ~asserted;
		end else begin
			alert_o     <= asserted;
			alert_oen_o <= 1'b0;
		end
	end

	always_comb begin
		case (idx)
			TAC_IDX_CFG: rd_data = cfg_view;
			TAC_IDX_UPPER: rd_data = thr_view(upper_q);
			TAC_IDX_LOWER: rd_data = thr_view(lower_q);
			default: rd_data = 16'h0000;
		endcase
	end

	// Unmapped addresses still acknowledge, read zero and store nothing.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q    <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req && !wb_we_i) begin
				wb_dat_o <= {16'h0000, rd_data};
			end
		end
	end

	assign wb_ack_o = ack_q;

endmodule
`default_nettype wire

// >>> hdl/tac_pkg.sv
// Constants and types shared by the temperature alarm control block.
package tac_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [5:0] TAC_IDX_CFG   = 6'h01;
	localparam logic [5:0] TAC_IDX_UPPER = 6'h02;
	localparam logic [5:0] TAC_IDX_LOWER = 6'h03;
	localparam int unsigned TAC_AW = 8;

	// Configuration register fields.
	localparam int unsigned TAC_CFG_MODE   = 0;
	localparam int unsigned TAC_CFG_POL    = 1;
	localparam int unsigned TAC_CFG_CRIT   = 2;
	localparam int unsigned TAC_CFG_EN     = 3;
	localparam int unsigned TAC_CFG_STS    = 4;
	localparam int unsigned TAC_CFG_CLR    = 5;
	localparam int unsigned TAC_CFG_WLOCK  = 6;
	localparam int unsigned TAC_CFG_CLOCK  = 7;
	localparam int unsigned TAC_CFG_SHDN   = 8;
	localparam int unsigned TAC_CFG_HYST_L = 9;
	localparam int unsigned TAC_CFG_HYST_H = 10;
	localparam logic [15:0] TAC_CFG_RESET  = 16'h0000;

	// Threshold register layout: sign in bit 12, value down to bit 2.
	localparam int unsigned TAC_THR_LSB   = 2;
	localparam int unsigned TAC_THR_MSB   = 12;
	localparam int unsigned TAC_THR_W     = 11;
	localparam logic [10:0] TAC_THR_RESET = 11'h000;

	// Temperature samples are 12-bit two's complement in eighths of a degree.
	localparam int unsigned TAC_TEMP_W = 12;
	localparam int unsigned TAC_CW     = 14;

	// Hysteresis codes 00..11 as 0, 1.5, 3.0 and 6.0 degrees in eighths.
	localparam logic [13:0] TAC_HYST_0  = 14'h0000;
	localparam logic [13:0] TAC_HYST_15 = 14'h000c;
	localparam logic [13:0] TAC_HYST_30 = 14'h0018;
	localparam logic [13:0] TAC_HYST_60 = 14'h0030;

	typedef enum logic {
		TAC_MODE_CMP = 1'b0,
		TAC_MODE_INT = 1'b1
	} tac_mode_t;

endpackage

// >>> hdl/tac_cmp_if.sv
// Link between the control block and its window comparator.
`timescale 1ns/1ps
`default_nettype none
interface tac_cmp_if;
	import tac_pkg::*;
	logic                  sample;
	logic [TAC_TEMP_W-1:0] temp;
	logic [TAC_THR_W-1:0]  upper;
	logic [TAC_THR_W-1:0]  lower;
	logic [1:0]            hyst;
	logic                  upper_cond;
	logic                  lower_cond;

	modport ctrl (
		output sample, temp, upper, lower, hyst,
		input  upper_cond, lower_cond
	);
	modport cmp (
		input  sample, temp, upper, lower, hyst,
		output upper_cond, lower_cond
	);
endinterface
`default_nettype wire

// >>> hdl/tac_window_cmp.sv
// Upper and lower alarm window comparator with falling hysteresis.
`timescale 1ns/1ps
`default_nettype none
module tac_window_cmp
	import tac_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Link to the control block
	tac_cmp_if.cmp    bus
);

	logic                     upper_q;
	logic                     lower_q;
	logic signed [TAC_CW-1:0] temp_e;
	logic signed [TAC_CW-1:0] upper_e;
	logic signed [TAC_CW-1:0] lower_e;
	logic signed [TAC_CW-1:0] hyst_e;

	// Thresholds are in quarters; one left shift brings them to eighths.
	function automatic logic [TAC_CW-1:0] thr_to_e8(
		input logic [TAC_THR_W-1:0] thr
	);
		thr_to_e8 = {{(TAC_CW-TAC_THR_W-1){thr[TAC_THR_W-1]}}, thr, 1'b0};
	endfunction

	assign temp_e  = {{(TAC_CW-TAC_TEMP_W){bus.temp[TAC_TEMP_W-1]}},
		bus.temp};
	assign upper_e = thr_to_e8(bus.upper);
	assign lower_e = thr_to_e8(bus.lower);

	always_comb begin
		case (bus.hyst)
			2'b00: hyst_e = TAC_HYST_0;
			2'b01: hyst_e = TAC_HYST_15;
			2'b10: hyst_e = TAC_HYST_30;
			2'b11: hyst_e = TAC_HYST_60;
			default: hyst_e = TAC_HYST_0;
		endcase
	end

	// Hysteresis only widens the clearing side of the upper limit.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			upper_q <= 1'b0;
		end else if (bus.sample) begin
			if (!upper_q && temp_e > upper_e) begin
				upper_q <= 1'b1;
			end else if (upper_q && temp_e <= upper_e - hyst_e) begin
				upper_q <= 1'b0;
			end
		end
	end

	// The lower limit trips below the limit minus hysteresis.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lower_q <= 1'b0;
		end else if (bus.sample) begin
			if (!lower_q && temp_e < lower_e - hyst_e) begin
				lower_q <= 1'b1;
			end else if (lower_q && temp_e >= lower_e) begin
				lower_q <= 1'b0;
			end
		end
	end

	assign bus.upper_cond = upper_q;
	assign bus.lower_cond = lower_q;

endmodule
`default_nettype wire

// >>> sim/tac_alarm_ctrl_asserts.sv
// Bus and alert pin checks for the temperature alarm control block.
`timescale 1ns/1ps
`default_nettype none
module tac_alarm_ctrl_asserts
	import tac_pkg::*;
(
	// Clock and reset
	input wire logic              clk_i,
	input wire logic              rst_i,
	// Register bus
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic [TAC_AW-1:0] wb_adr_i,
	input wire logic [31:0]       wb_dat_o,
	input wire logic              wb_ack_o,
	// Alert pin
	input wire logic              alert_o,
	input wire logic              alert_oen_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic       req;
	logic       rd_cfg;
	logic       rd_thr;
	logic       rdc_q;
	logic [1:0] lk_q;
	assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd_cfg = req && !wb_we_i && wb_adr_i[7:2] == TAC_IDX_CFG;
	assign rd_thr = req && !wb_we_i && (wb_adr_i[7:2] == TAC_IDX_UPPER ||
		wb_adr_i[7:2] == TAC_IDX_LOWER);
	// Remembers every lock bit ever read as set, so a later clear shows.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdc_q <= 1'b0;
			lk_q  <= 2'b00;
		end else begin
			rdc_q <= rd_cfg;
			if (rdc_q && wb_ack_o)
				lk_q <= lk_q | wb_dat_o[7:6];
		end
	end
	a_ack_follows_req: assert property (req |=> wb_ack_o)
		else $error("no ack after request");
	a_ack_needs_req: assert property (!req |=> !wb_ack_o)
		else $error("ack without request");
	a_rd_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
		else $error("upper read half not zero");
	a_thr_rsvd_zero: assert property (rd_thr |=> wb_dat_o[15:13] == 3'h0 &&
		wb_dat_o[1:0] == 2'h0) else $error("reserved threshold bits set");
	a_cfg_clr_zero: assert property (rd_cfg |=> !wb_dat_o[5] &&
		wb_dat_o[15:11] == 5'h0) else $error("clear or spare bits read one");
	a_sts_drives: assert property (rd_cfg ##1 wb_dat_o[4] |->
		!$past(alert_oen_o) && $past(alert_o) == wb_dat_o[1])
		else $error("status set but pin not asserted");
	a_idle_level: assert property (rd_cfg ##1 !wb_dat_o[4] |->
		(wb_dat_o[1] ? ($past(alert_oen_o) || !$past(alert_o))
		: $past(alert_oen_o))) else $error("idle pin level wrong");
	a_off_no_alert: assert property (rd_cfg ##1 (!wb_dat_o[3] ||
		wb_dat_o[8]) |-> !wb_dat_o[4]) else $error("status set while off");
	a_shdn_release: assert property (rd_cfg ##1 wb_dat_o[8] |->
		$past(alert_oen_o)) else $error("pin driven in shutdown");
	a_lock_sticky: assert property (rdc_q && wb_ack_o |->
		(wb_dat_o[7:6] & lk_q) == lk_q) else $error("lock bit cleared");
endmodule
bind tac_alarm_ctrl tac_alarm_ctrl_asserts chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .alert_o(alert_o), .alert_oen_o(alert_oen_o)
);
`default_nettype wire

// >>> sim/tac_sensor_model.sv
// Sensor front end model: sample clock, temperature and critical level.
`timescale 1ns/1ps
`default_nettype none
module tac_sensor_model (
	// Control from the bench
	input  wire logic        run_i,
	input  wire logic [11:0] temp_set_i,
	input  wire logic        crit_set_i,
	// Link to the block
	output logic             sample_clk_o,
	output logic      [11:0] temp_o,
	output logic             crit_o
);
	// The offset keeps the link clock out of phase with the system clock.
	// Data moves with the falling edge so it is stable around each sample,
	// and one process drives every link output so none has two sources.
	initial begin
		sample_clk_o = 1'b0;
		temp_o       = 12'h000;
		crit_o       = 1'b0;
		#3;
		forever begin
			#40;
			if (sample_clk_o) begin
				temp_o = temp_set_i;
				crit_o = crit_set_i;
			end
			sample_clk_o = run_i & ~sample_clk_o;
		end
	end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the temperature alarm control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import tac_pkg::*;
;
	logic        clk, rst, cyc, stb, we, ack, sclk, crit, aout, aoen;
	logic        run, crit_set;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dwr, drd;
	logic [11:0] temp, temp_set;
	logic [15:0] rnd;
	logic [15:0] expq[$];
	int          error_cnt, tests_run, seed;
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	tac_alarm_ctrl dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack), .sample_clk_i(sclk),
		.temp_i(temp), .crit_alarm_i(crit), .alert_o(aout),
		.alert_oen_o(aoen));
	tac_sensor_model snsr_u (.run_i(run), .temp_set_i(temp_set),
		.crit_set_i(crit_set), .sample_clk_o(sclk), .temp_o(temp),
		.crit_o(crit));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [5:0] i, input logic [15:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= {i, 2'b00};
		dwr <= {16'h0000, d};
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] i, input logic [15:0] e);
		expq.push_back(e);
		wb(1'b0, i, 16'h0000);
	endtask
	task automatic st(input logic [11:0] t, input logic c);
		@(posedge clk);
		temp_set <= t;
		crit_set <= c;
	endtask
	// Long enough for one full sample period plus the link latency.
	task automatic pin(input logic [1:0] e);
		repeat (32) @(posedge clk);
		chk({30'h0, aoen, aout}, {30'h0, e});
	endtask
	task automatic do_reset;
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	always @(posedge clk)
		if (ack === 1'b1 && we === 1'b0)
			chk(drd, {16'h0000, expq.pop_front()});
	// The scenarios need about seven hundred cycles, so this only ends a hang.
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		give_verdict;
	end
	initial begin
		seed = 32'hf1927289;
		{rst, cyc, stb, we, adr, sel, dwr} = {4'h8, 8'h00, 4'h3, 32'h0};
		{run, temp_set, crit_set, error_cnt, tests_run} = '0;
		run = 1'b1;
		do_reset;
		rd(TAC_IDX_CFG, 16'h0000);
		rd(TAC_IDX_UPPER, 16'h0000);
		rd(TAC_IDX_LOWER, 16'h0000);
		rd(6'h3f, 16'h0000);
		pin(2'b10);
		wb(1'b1, TAC_IDX_UPPER, 16'hffff);
		rd(TAC_IDX_UPPER, 16'h1ffc);
		rnd = 16'($random(seed));
		wb(1'b1, TAC_IDX_LOWER, rnd);
		rd(TAC_IDX_LOWER, rnd & 16'h1ffc);
		wb(1'b1, TAC_IDX_LOWER, 16'h1f00);
		wb(1'b1, TAC_IDX_UPPER, 16'h0190);
		st(12'h0f0, 1'b0);
		wb(1'b1, TAC_IDX_CFG, 16'h0008);
		pin(2'b00);
		rd(TAC_IDX_CFG, 16'h0018);
		wb(1'b1, TAC_IDX_CFG, 16'h020a);
		pin(2'b01);
		st(12'h0c0, 1'b0);
		pin(2'b01);
		st(12'h0bc, 1'b0);
		pin(2'b00);
		st(12'hf60, 1'b0);
		pin(2'b01);
		st(12'h0a0, 1'b0);
		pin(2'b00);
		wb(1'b1, TAC_IDX_CFG, 16'h060a);
		st(12'h0f0, 1'b0);
		pin(2'b01);
		st(12'h0a0, 1'b0);
		pin(2'b01);
		wb(1'b1, TAC_IDX_CFG, 16'h040a);
		pin(2'b00);
		wb(1'b1, TAC_IDX_CFG, 16'h020b);
		st(12'h0f0, 1'b0);
		pin(2'b01);
		st(12'h0a0, 1'b0);
		pin(2'b01);
		wb(1'b1, TAC_IDX_CFG, 16'h022b);
		pin(2'b00);
		rd(TAC_IDX_CFG, 16'h020b);
		wb(1'b1, TAC_IDX_CFG, 16'h0206);
		wb(1'b1, TAC_IDX_CFG, 16'h020e);
		st(12'h0f0, 1'b0);
		pin(2'b00);
		st(12'h0f0, 1'b1);
		pin(2'b01);
		wb(1'b1, TAC_IDX_CFG, 16'h030e);
		repeat (32) @(posedge clk);
		chk({31'h0, aoen}, 32'h1);
		rd(TAC_IDX_CFG, 16'h030e);
		wb(1'b1, TAC_IDX_CFG, 16'h020e);
		pin(2'b01);
		rd(TAC_IDX_CFG, 16'h021e);
		wb(1'b1, TAC_IDX_CFG, 16'h024e);
		wb(1'b1, TAC_IDX_UPPER, 16'h0000);
		rd(TAC_IDX_UPPER, 16'h0190);
		wb(1'b1, TAC_IDX_CFG, 16'h0000);
		rd(TAC_IDX_CFG, 16'h025e);
		do_reset;
		wb(1'b1, TAC_IDX_CFG, 16'h0080);
		wb(1'b1, TAC_IDX_CFG, 16'h0084);
		rd(TAC_IDX_CFG, 16'h0084);
		wb(1'b1, TAC_IDX_CFG, 16'h008f);
		rd(TAC_IDX_CFG, 16'h0084);
		repeat (2) @(posedge clk);
		give_verdict;
	end
endmodule
`default_nettype wire
